// ==== hw/vtf_pkg.sv ====
// Constants, field positions and carrier types for the vicinity tag framing codec.
// Assumes one 20 MHz core clock; the reader link clock is sampled as plain data.
// Overview of operation
// - Tag answers only after a request was received and checked good.
// - Requests and responses each sit in one frame, opened and closed by delimiters.
// - Frame bit count between delimiters is a whole multiple of eight.
// - Bits go out LSB first; multi-byte fields go out low byte first.
// - Flag bit 2 decides whether bits 4 to 7 mean selection or inventory.
// - Flag bit 0 picks one or two subcarriers for the response.
// - Flag bit 1 picks low or high response data rate.
// - Select bit set: no identifier, served only while tag is selected.
// - Address bit set: identifier present, served only if it matches own identifier.
// - Select and address bits both set: request ignored, no response.
// - Inventory: bit 4 says whether the family identifier byte is present.
// - Inventory: bit 5 clear means sixteen slots, set means one slot.
// - Response is flag byte, optional data, then 16-bit CRC.
// - Response flag bit 0 set on error, with error code as data.
// - Response flag bits 1 to 7 are always zero.
// - Errors on inventory or broadcast requests are answered with silence.
package vtf_pkg;

  localparam int unsigned FLAG_SUBCAR = 0;
  localparam int unsigned FLAG_RATE   = 1;
  localparam int unsigned FLAG_INV    = 2;
  localparam int unsigned FLAG_EXT    = 3;
  localparam int unsigned FLAG_SEL    = 4;  // Family identifier present in inventory
  localparam int unsigned FLAG_ADDR   = 5;  // One slot in inventory
  localparam int unsigned FLAG_OPT    = 6;
  localparam int unsigned FLAG_RFU    = 7;

  localparam logic [7:0]  RSP_FLAGS_OK  = 8'h00;
  localparam logic [7:0]  RSP_FLAGS_ERR = 8'h01;

  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;

  localparam int unsigned BUF_AW        = 5;
  localparam int unsigned BUF_DEPTH     = 32;
  localparam logic [5:0]  MIN_REQ_BYTES = 6'h04;
  localparam logic [5:0]  HDR_BYTES     = 6'h02;
  localparam logic [5:0]  UID_BYTES     = 6'h08;
  localparam logic [5:0]  CRC_BYTES     = 6'h02;
  localparam logic [2:0]  LAST_BIT      = 3'h7;

  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_UID_LO = 12'h004;
  localparam logic [11:0] REG_UID_HI = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_COUNT  = 12'h010;

  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_SELECTED = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  localparam logic [63:0] UID_RST       = 64'h0;  // Arbitrary until software loads it

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] opcode;
    logic       inventory;
    logic       ext_set;
    logic       sel_mode;
    logic       addr_mode;
    logic       afi_present;
    logic       one_slot;
    logic       option;
    logic       rfu;
    logic [5:0] param_off;
    logic [5:0] nbytes;
  } vtf_req_t;

  typedef struct packed {
    logic       err;
    logic [7:0] code;
    logic [5:0] len;
  } vtf_rsp_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic frame;
  } vtf_link_t;

  typedef struct packed {
    logic data;
    logic frame;
    logic two_sub;
    logic high_rate;
  } vtf_tx_t;

endpackage : vtf_pkg

// ==== hw/vtf_req_buf.sv ====
// Byte store for one received request frame, registered read port.
// Assumes a single writer (frame receiver) and a single reader (command handling).
`timescale 1ns/1ns
module vtf_req_buf
  import vtf_pkg::*;
(
  input  wire logic              i_clock,  // Core clock
  input  wire logic              i_we,     // Write strobe
  input  wire logic [BUF_AW-1:0] i_waddr,  // Write byte index
  input  wire logic [7:0]        i_wdata,  // Write byte
  input  wire logic [BUF_AW-1:0] i_raddr,  // Read byte index
  output logic      [7:0]        o_rdata   // Read byte, one cycle later
);
  logic [7:0] mem_q [BUF_DEPTH];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    o_rdata <= mem_q[i_raddr];
  end
endmodule : vtf_req_buf

// ==== hw/vtf_frame_codec.sv ====
// Tag-side request parser and response framer with APB control registers.
// Assumes link pins are asynchronous; the link clock is sampled, bits taken on its rising edge.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module vtf_frame_codec
  import vtf_pkg::*;
(
  input  wire logic              i_clock,     // 20 MHz core clock
  input  wire logic              i_rst_n,     // Synchronous reset, active low
  input  wire logic              i_psel,      // APB select
  input  wire logic              i_penable,   // APB enable
  input  wire logic              i_pwrite,    // APB write
  input  wire logic [11:0]       i_paddr,     // APB byte address
  input  wire logic [31:0]       i_pwdata,    // APB write data
  output logic      [31:0]       o_prdata,    // APB read data
  output logic                   o_pready,    // APB ready
  output logic                   o_pslverr,   // APB error on unmapped address
  input  wire vtf_pkg::vtf_link_t i_link,     // Demodulated reader link
  output vtf_pkg::vtf_tx_t       o_tx,        // Response bit stream and mode
  output logic                   o_req_valid, // Good request pulse
  output vtf_pkg::vtf_req_t      o_req,       // Decoded request
  input  wire logic [BUF_AW-1:0] i_buf_addr,  // Request byte index
  output logic      [7:0]        o_buf_data,  // Request byte, one cycle later
  input  wire logic              i_rsp_go,    // Start response pulse
  input  wire vtf_pkg::vtf_rsp_t i_rsp,       // Response descriptor
  output logic      [5:0]        o_rsp_idx,   // Response data byte wanted
  input  wire logic [7:0]        i_rsp_byte,  // Response data byte
  output logic                   o_tx_busy    // Response frame in progress
);
  import vtf_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_END} vtf_tx_st_t;

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    logic [15:0] s;
    s = c >> 1;
    crc_bit = (c[0] ^ b) ? (s ^ CRC_POLY) : s;
  endfunction : crc_bit

  // Three-stage link sampling; a change is taken once stages two and three agree
  logic [2:0] s1_q, s2_q, s3_q, f_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      f_q  <= 3'h0;
    end else begin
      s1_q <= {i_link.clk, i_link.data, i_link.frame};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          f_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic [2:0] fp_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) fp_q <= 3'h0;
    else          fp_q <= f_q;
  end

  logic lk_rise, lk_fall, fr_open, fr_close;
  assign lk_rise  = f_q[2] & ~fp_q[2];
  assign lk_fall  = ~f_q[2] & fp_q[2];
  assign fr_open  = f_q[0] & ~fp_q[0];   // Start delimiter seen
  assign fr_close = ~f_q[0] & fp_q[0];   // End delimiter seen

  // Registers
  logic [1:0]  ctrl_q;
  logic [63:0] uid_q;
  logic [7:0]  cnt_ok_q, cnt_drop_q;
  logic [7:0]  last_flags_q;
  logic        wr_en, rd_en, hit;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  assign hit   = (i_paddr == REG_CTRL) | (i_paddr == REG_UID_LO) | (i_paddr == REG_UID_HI) |
                 (i_paddr == REG_STATUS) | (i_paddr == REG_COUNT);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RST;
      uid_q  <= UID_RST;
    end else if (wr_en) begin
      case (i_paddr)
        REG_CTRL:   ctrl_q        <= i_pwdata[1:0];
        REG_UID_LO: uid_q[31:0]   <= i_pwdata;
        REG_UID_HI: uid_q[63:32]  <= i_pwdata;
        default:    ctrl_q        <= ctrl_q;
      endcase
    end
  end

  // Receive path
  logic [7:0]  rx_sh_q;
  logic [2:0]  rx_bit_q;
  logic [5:0]  rx_cnt_q;
  logic [15:0] rx_crc_q;
  logic        rx_uid_ok_q, rx_ovf_q, rx_on_q;
  logic [7:0]  rx_byte;
  logic        rx_done;
  assign rx_byte = {f_q[1], rx_sh_q[7:1]};                       // LSB first
  assign rx_done = rx_on_q & lk_rise & (rx_bit_q == LAST_BIT);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rx_on_q     <= 1'b0;
      rx_sh_q     <= 8'h00;
      rx_bit_q    <= 3'h0;
      rx_cnt_q    <= 6'h00;
      rx_crc_q    <= CRC_INIT;
      rx_uid_ok_q <= 1'b1;
      rx_ovf_q    <= 1'b0;
    end else if (fr_open) begin
      rx_on_q     <= ctrl_q[CTRL_EN];
      rx_bit_q    <= 3'h0;
      rx_cnt_q    <= 6'h00;
      rx_crc_q    <= CRC_INIT;
      rx_uid_ok_q <= 1'b1;
      rx_ovf_q    <= 1'b0;
    end else if (fr_close) begin
      rx_on_q <= 1'b0;
    end else if (rx_on_q && lk_rise) begin
      rx_sh_q  <= rx_byte;
      rx_bit_q <= rx_bit_q + 3'h1;
      rx_crc_q <= crc_bit(rx_crc_q, f_q[1]);
      if (rx_bit_q == LAST_BIT) begin
        rx_cnt_q <= rx_cnt_q + 6'h01;
        if (rx_cnt_q == 6'(BUF_DEPTH)) rx_ovf_q <= 1'b1;
        if (rx_cnt_q >= HDR_BYTES && rx_cnt_q < HDR_BYTES + UID_BYTES &&
            rx_byte != uid_q[3'(rx_cnt_q - HDR_BYTES) * 8 +: 8]) begin
          rx_uid_ok_q <= 1'b0;
        end
      end
    end
  end

  vtf_req_buf u_buf (
    .i_clock (i_clock),
    .i_we    (rx_done && rx_cnt_q < 6'(BUF_DEPTH)),
    .i_waddr (rx_cnt_q[BUF_AW-1:0]),
    .i_wdata (rx_byte),
    .i_raddr (i_buf_addr),
    .o_rdata (o_buf_data)
  );

  // Opcode and flags kept as they arrive
  logic [7:0] rx_flags_q, rx_op_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rx_flags_q <= 8'h00;
      rx_op_q    <= 8'h00;
    end else if (rx_done && rx_cnt_q == 6'h00) begin
      rx_flags_q <= rx_byte;
    end else if (rx_done && rx_cnt_q == 6'h01) begin
      rx_op_q <= rx_byte;
    end
  end

  // Frame acceptance at end delimiter
  logic inv, sel, adr, frame_ok, mode_ok, accept;
  assign inv = rx_flags_q[FLAG_INV];
  assign sel = rx_flags_q[FLAG_SEL];
  assign adr = rx_flags_q[FLAG_ADDR];
  assign frame_ok = rx_on_q & (rx_bit_q == 3'h0)
                  & (rx_cnt_q >= MIN_REQ_BYTES)
                  & ~rx_ovf_q & (rx_crc_q == CRC_RESIDUE);
  always_comb begin
    if (inv) begin
      mode_ok = 1'b1;
    end else if (sel && adr) begin
      mode_ok = 1'b0;
    end else if (sel) begin
      mode_ok = ctrl_q[CTRL_SELECTED];
    end else if (adr) begin
      mode_ok = rx_uid_ok_q & (rx_cnt_q >= HDR_BYTES + UID_BYTES + CRC_BYTES);
    end else begin
      mode_ok = 1'b1;
    end
  end
  assign accept = fr_close & frame_ok & mode_ok;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_req_valid <= 1'b0;
      o_req       <= '0;
    end else begin
      o_req_valid <= accept;
      if (accept) begin
        o_req.flags       <= rx_flags_q;
        o_req.opcode      <= rx_op_q;
        o_req.inventory   <= inv;
        o_req.ext_set     <= rx_flags_q[FLAG_EXT];
        o_req.sel_mode    <= ~inv & sel;
        o_req.addr_mode   <= ~inv & adr;
        o_req.afi_present <= inv & sel;
        o_req.one_slot    <= inv & adr;
        o_req.option      <= rx_flags_q[FLAG_OPT];
        o_req.rfu         <= rx_flags_q[FLAG_RFU];
        o_req.param_off   <= (~inv & adr) ? HDR_BYTES + UID_BYTES : HDR_BYTES;
        o_req.nbytes      <= rx_cnt_q - CRC_BYTES;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cnt_ok_q     <= 8'h00;
      cnt_drop_q   <= 8'h00;
      last_flags_q <= 8'h00;
    end else if (fr_close && rx_on_q) begin
      if (accept) begin
        cnt_ok_q     <= cnt_ok_q + 8'h01;
        last_flags_q <= rx_flags_q;
      end else begin
        cnt_drop_q <= cnt_drop_q + 8'h01;
      end
    end
  end

  // Response may start only while a good request is pending
  logic pend_q, silent_q;
  logic rsp_take, tx_done;
  assign rsp_take = i_rsp_go & pend_q & ~(i_rsp.err & silent_q);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pend_q   <= 1'b0;
      silent_q <= 1'b0;
    end else if (accept) begin
      pend_q   <= 1'b1;
      silent_q <= inv | (~sel & ~adr);
    end else if (i_rsp_go || fr_open) begin
      pend_q <= 1'b0;
    end
  end

  // Transmit path
  vtf_tx_st_t  tx_st_q;
  logic [7:0]  tx_sh_q, tx_cur;
  logic [2:0]  tx_bit_q;
  logic [5:0]  tx_idx_q, tx_nd_q;
  logic [15:0] tx_crc_q;
  logic        tx_err_q;
  logic [7:0]  tx_code_q;
  logic        tx_body;
  assign tx_body   = tx_idx_q <= tx_nd_q;
  assign o_rsp_idx = tx_idx_q - 6'h01;
  assign o_tx_busy = tx_st_q != TX_IDLE;

  always_comb begin
    if (tx_idx_q == 6'h00) begin
      tx_cur = tx_err_q ? RSP_FLAGS_ERR : RSP_FLAGS_OK;
    end else if (tx_body) begin
      tx_cur = tx_err_q ? tx_code_q : i_rsp_byte;
    end else if (tx_idx_q == tx_nd_q + 6'h01) begin
      tx_cur = ~tx_crc_q[7:0];
    end else begin
      tx_cur = ~tx_crc_q[15:8];
    end
  end
  assign tx_done = (tx_bit_q == LAST_BIT) & (tx_idx_q == tx_nd_q + CRC_BYTES);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 8'h00;
      tx_bit_q  <= 3'h0;
      tx_idx_q  <= 6'h00;
      tx_nd_q   <= 6'h00;
      tx_crc_q  <= CRC_INIT;
      tx_err_q  <= 1'b0;
      tx_code_q <= 8'h00;
      o_tx      <= '0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (rsp_take) begin
            tx_st_q   <= TX_SEND;
            tx_err_q  <= i_rsp.err;
            tx_code_q <= i_rsp.code;
            tx_nd_q   <= i_rsp.err ? 6'h01 : i_rsp.len;
            tx_idx_q  <= 6'h00;
            tx_bit_q  <= 3'h0;
            tx_crc_q  <= CRC_INIT;
            o_tx.two_sub   <= o_req.flags[FLAG_SUBCAR];
            o_tx.high_rate <= o_req.flags[FLAG_RATE];
          end
        end
        TX_SEND: begin
          if (lk_fall) begin
            o_tx.frame <= 1'b1;
            o_tx.data  <= (tx_bit_q == 3'h0) ? tx_cur[0] : tx_sh_q[0];
            tx_sh_q    <= (tx_bit_q == 3'h0) ? (tx_cur >> 1) : (tx_sh_q >> 1);
            if (tx_body) begin
              tx_crc_q <= crc_bit(tx_crc_q, (tx_bit_q == 3'h0) ? tx_cur[0] : tx_sh_q[0]);
            end
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == LAST_BIT) tx_idx_q <= tx_idx_q + 6'h01;
            if (tx_done) tx_st_q <= TX_END;
          end
        end
        TX_END: begin
          if (lk_fall) begin
            o_tx.frame <= 1'b0;
            o_tx.data  <= 1'b0;
            tx_st_q    <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Read data registered in the setup phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0;
    end else if (rd_en) begin
      case (i_paddr)
        REG_CTRL:   o_prdata <= {30'h0, ctrl_q};
        REG_UID_LO: o_prdata <= uid_q[31:0];
        REG_UID_HI: o_prdata <= uid_q[63:32];
        REG_STATUS: o_prdata <= {21'h0, o_tx.high_rate, o_tx.two_sub, o_tx_busy, last_flags_q};
        REG_COUNT:  o_prdata <= {16'h0, cnt_drop_q, cnt_ok_q};
        default:    o_prdata <= 32'h0;
      endcase
    end
  end
endmodule : vtf_frame_codec

// ==== bench/vtf_codec_properties.sv ====
// Port-level checks of the framing codec.
// Assumes the link clock period is eight core clocks.
`timescale 1ns/1ns
module vtf_codec_properties
  import vtf_pkg::*;
(
  input wire logic              i_clock,     // Core clock
  input wire logic              i_rst_n,     // Reset, active low
  input wire logic              i_psel,      // APB select
  input wire logic              i_penable,   // APB enable
  input wire logic              i_pwrite,    // APB write
  input wire logic [11:0]       i_paddr,     // APB address
  input wire logic [31:0]       i_pwdata,    // APB write data
  input wire vtf_pkg::vtf_tx_t  o_tx,        // Response stream
  input wire logic              o_req_valid, // Good request
  input wire vtf_pkg::vtf_req_t o_req,       // Decoded request
  input wire logic              i_rsp_go,    // Start response
  input wire vtf_pkg::vtf_rsp_t i_rsp,       // Response descriptor
  input wire logic              o_tx_busy    // Response running
);
  logic        sel_q;
  logic        err_q;
  logic [11:0] cyc_q;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sel_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (i_psel && i_penable && i_pwrite && i_paddr == REG_CTRL) sel_q <= i_pwdata[CTRL_SELECTED];
      if (i_rsp_go && !o_tx_busy) err_q <= i_rsp.err;
    end
  end
  // Cycles since the response frame opened
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !o_tx.frame) cyc_q <= 12'h000;
    else cyc_q <= cyc_q + 12'h001;
  end
  tx_after_go_a: assert property ($rose(o_tx_busy) |-> $past(i_rsp_go))
    else $error("response started without a start request");
  frame_in_busy_a: assert property (o_tx.frame |-> o_tx_busy)
    else $error("response frame outside busy");
  whole_bytes_a: assert property ($fell(o_tx.frame) |-> cyc_q != 12'h000 && cyc_q[5:0] == 6'h00)
    else $error("response bit count not whole bytes");
  err_bit_a: assert property ($rose(o_tx.frame) |-> o_tx.data == err_q)
    else $error("first response bit differs from error state");
  rfu_zero_a: assert property (o_tx.frame && cyc_q >= 12'h008 && cyc_q < 12'h040 |-> !o_tx.data)
    else $error("reserved response flag bit set");
  subcar_mode_a: assert property (o_tx.frame |-> o_tx.two_sub == o_req.flags[FLAG_SUBCAR])
    else $error("subcarrier mode differs from request");
  rate_mode_a: assert property (o_tx.frame |-> o_tx.high_rate == o_req.flags[FLAG_RATE])
    else $error("data rate differs from request");
  flag_split_a: assert property (o_req_valid |-> o_req.inventory == o_req.flags[FLAG_INV] &&
    (o_req.inventory ? {o_req.one_slot, o_req.afi_present} : {o_req.addr_mode, o_req.sel_mode}) == o_req.flags[5:4])
    else $error("request flag bits 4 and 5 decoded wrongly");
  pass_bits_a: assert property (o_req_valid |-> {o_req.rfu, o_req.option, o_req.ext_set} ==
    {o_req.flags[FLAG_RFU], o_req.flags[FLAG_OPT], o_req.flags[FLAG_EXT]})
    else $error("option or reserved bit altered");
  no_both_a: assert property (o_req_valid && !o_req.inventory |-> !(o_req.sel_mode && o_req.addr_mode))
    else $error("request with select and address accepted");
  sel_state_a: assert property (o_req_valid && !o_req.inventory && o_req.sel_mode |-> sel_q)
    else $error("select request accepted while not selected");
  silent_err_a: assert property (i_rsp_go && !o_tx_busy && i_rsp.err &&
    (o_req.inventory || !(o_req.sel_mode || o_req.addr_mode)) |=> !o_tx_busy [*4])
    else $error("error answered where silence is due");
  cover property (o_req_valid && o_req.inventory);
  cover property (o_req_valid && o_req.addr_mode);
  cover property ($fell(o_tx.frame));
endmodule : vtf_codec_properties

bind vtf_frame_codec vtf_codec_properties chk_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_tx(o_tx),
  .o_req_valid(o_req_valid), .o_req(o_req), .i_rsp_go(i_rsp_go), .i_rsp(i_rsp), .o_tx_busy(o_tx_busy));

// ==== bench/vtf_reader_model.sv ====
// Behavioural reader: sends request frames and clocks and captures responses.
// Assumes the tag moves its response bit after each link clock fall.
`timescale 1ns/1ns
module vtf_reader_model
  import vtf_pkg::*;
(
  output vtf_pkg::vtf_link_t     o_link, // Link towards the tag
  input  wire vtf_pkg::vtf_tx_t  i_tx    // Response from the tag
);
  logic rx_bits[$];
  initial o_link = '{1'b0, 1'b1, 1'b0};
  // Clock runs only inside frames; layout and check bytes come from the caller
  task automatic send(input logic [7:0] b[$]);
    // Offset keeps link changes off core clock edges
    #10;
    o_link.frame = 1'b1;
    #200;
    foreach (b[i]) begin
      for (int k = 0; k < 8; k++) begin
        o_link.data = b[i][k];
        #200 o_link.clk = 1'b1;
        #200 o_link.clk = 1'b0;
      end
    end
    o_link.frame = 1'b0;
    o_link.data = ~o_link.data;
  endtask : send
  // Bits are taken just before each fall, after standing for about half a period
  task automatic listen(input int n);
    #10;
    for (int k = 0; k < n; k++) begin
      #200 o_link.clk = 1'b1;
      #200;
      if (i_tx.frame === 1'b1) rx_bits.push_back(i_tx.data);
      o_link.clk = 1'b0;
    end
  endtask : listen
endmodule : vtf_reader_model

// ==== bench/vicinity_tag_frame_flags_codec_test.sv ====
// Self-checking bench of the framing codec: registers, request frames, responses.
// Assumes the reader model on the link and a 20 MHz core clock.
`timescale 1ns/1ns
module vicinity_tag_frame_flags_codec_test;
  import vtf_pkg::*;
  logic              i_clock, i_rst_n, i_psel, i_penable, i_pwrite, i_rsp_go;
  logic              o_pready, o_pslverr, o_req_valid, o_tx_busy;
  logic [11:0]       i_paddr;
  logic [31:0]       i_pwdata, o_prdata;
  vtf_link_t         i_link;
  vtf_tx_t           o_tx;
  vtf_req_t          o_req;
  vtf_rsp_t          i_rsp;
  logic [BUF_AW-1:0] i_buf_addr;
  logic [7:0]        o_buf_data, i_rsp_byte, last_fl;
  logic [5:0]        o_rsp_idx;
  logic [7:0]        rsp_mem [64];
  logic [63:0]       uid;
  int                fail_count, compares, vcount, seed;

  vtf_frame_codec dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_link(i_link), .o_tx(o_tx), .o_req_valid(o_req_valid), .o_req(o_req),
    .i_buf_addr(i_buf_addr), .o_buf_data(o_buf_data), .i_rsp_go(i_rsp_go), .i_rsp(i_rsp),
    .o_rsp_idx(o_rsp_idx), .i_rsp_byte(i_rsp_byte), .o_tx_busy(o_tx_busy));
  vtf_reader_model rd_u (.o_link(i_link), .i_tx(o_tx));
  assign i_rsp_byte = rsp_mem[o_rsp_idx];

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (o_req_valid === 1'b1) vcount <= vcount + 1;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc16
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    chk("pready", o_pready, 32'h1);
  endtask : apb
  task automatic req(input logic [7:0] fl, input int extra, input logic bad, input logic [63:0] id, input int exp);
    logic [7:0]  q[$];
    logic [15:0] c;
    int          n0;
    last_fl = fl;
    q = {fl, 8'($random(seed))};
    if (!fl[FLAG_INV] && fl[FLAG_ADDR]) for (int i = 0; i < 8; i++) q.push_back(id[8*i +: 8]);
    repeat (extra) q.push_back(8'($random(seed)));
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    n0 = vcount;
    rd_u.send(q);
    repeat (10) @(posedge i_clock);
    chk("req_valid", vcount - n0, exp);
    if (exp == 1) begin
      chk("req_flags", o_req.flags, fl);
      chk("req_nbytes", o_req.nbytes, q.size() - 2);
      i_buf_addr <= 5'h01;
      repeat (2) @(posedge i_clock);
      chk("buf_opcode", o_buf_data, q[1]);
    end
  endtask : req
  task automatic rsp(input logic err, input int len, input logic tx);
    logic [7:0]  e[$];
    logic [7:0]  code;
    logic [15:0] c;
    code = 8'($random(seed));
    e = {err ? RSP_FLAGS_ERR : RSP_FLAGS_OK};
    for (int i = 0; i < len; i++) begin
      rsp_mem[i] = 8'($random(seed));
      e.push_back(err ? code : rsp_mem[i]);
    end
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    @(posedge i_clock);
    i_rsp_go <= 1'b1;
    i_rsp <= '{err, code, 6'(len)};
    @(posedge i_clock);
    i_rsp_go <= 1'b0;
    @(posedge i_clock);
    chk("tx_busy", o_tx_busy, tx);
    if (tx) chk("tx_modes", {o_tx.two_sub, o_tx.high_rate}, {last_fl[0], last_fl[1]});
    rd_u.rx_bits.delete();
    rd_u.listen(8 * e.size() + 3);
    chk("rsp_bits", rd_u.rx_bits.size(), tx ? 8 * e.size() : 0);
    foreach (rd_u.rx_bits[i]) chk("rsp_bit", rd_u.rx_bits[i], e[i/8][i%8]);
    chk("tx_idle", o_tx_busy, 32'h0);
  endtask : rsp

  initial begin
    logic [31:0] r;
    logic        e;
    seed = 32'hCA9C;
    {i_rst_n, i_psel, i_penable, i_pwrite, i_rsp_go} = 5'h00;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_buf_addr = 5'h00;
    i_rsp = '0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    chk("ctrl_reset", r, 32'(CTRL_RST));
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk("unmapped", {r[30:0], e}, 32'h1);
    uid = {$random(seed), $random(seed)};
    apb(1'b1, REG_UID_LO, uid[31:0], r, e);
    apb(1'b1, REG_UID_HI, uid[63:32], r, e);
    apb(1'b0, REG_UID_HI, 32'h0, r, e);
    chk("uid_hi", r, uid[63:32]);
    // Broadcast requests with random rate, subcarrier, option and reserved bits
    repeat (4) begin
      req(8'($random(seed)) & 8'hC3, {$random(seed)} % 7, 1'b0, uid, 1);
      rsp(1'b0, {$random(seed)} % 5, 1'b1);
    end
    req(8'h02, 0, 1'b1, uid, 0);
    req(8'h30, 8, 1'b0, uid, 0);
    req(8'h10, 1, 1'b0, uid, 0);
    apb(1'b1, REG_CTRL, 32'h3, r, e);
    req(8'h11, 1, 1'b0, uid, 1);
    rsp(1'b1, 1, 1'b1);
    req(8'h20, 2, 1'b0, ~uid, 0);
    req(8'h23, 2, 1'b0, uid, 1);
    chk("param_off", o_req.param_off, 32'hA);
    rsp(1'b0, 3, 1'b1);
    req(8'h36, 1, 1'b0, uid, 1);
    chk("inv_bits", {o_req.afi_present, o_req.one_slot}, 32'h3);
    rsp(1'b1, 1, 1'b0);
    rsp(1'b0, 2, 1'b0);
    req(8'h06, 0, 1'b0, uid, 1);
    chk("inv_bits", {o_req.afi_present, o_req.one_slot}, 32'h0);
    req(8'h00, 0, 1'b0, uid, 1);
    rsp(1'b1, 1, 1'b0);
    // Receiver switched off: frame neither taken nor counted
    apb(1'b1, REG_CTRL, 32'h2, r, e);
    req(8'h00, 0, 1'b0, uid, 0);
    apb(1'b0, REG_COUNT, 32'h0, r, e);
    chk("count", r, 32'h0409);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    chk("status", r, 32'h0600);
    summarize();
  end
  initial begin
    #3000000;
    fail_count++;
    summarize();
  end
endmodule : vicinity_tag_frame_flags_codec_test
